// >>> verilog/adc_ctrl_pkg.sv
// Package for the audio converter control register bank.
// Assumes a single clock domain and a byte-wide register access port.
package adc_ctrl_pkg;
	// Register offsets on page zero.
	localparam logic [7:0] OFS_PAGE     = 8'h00;
	localparam logic [7:0] OFS_SOFT_RST = 8'h01;
	localparam logic [7:0] OFS_SLEEP    = 8'h02;
	localparam logic [7:0] OFS_SHUTDOWN = 8'h05;
	localparam logic [7:0] OFS_SERIAL0  = 8'h07;
	localparam logic [7:0] PAGE_ZERO    = 8'h00;

	// Power-on values.
	localparam logic [7:0] RST_PAGE     = 8'h00;
	localparam logic [7:0] RST_SLEEP    = 8'h00;
	localparam logic [7:0] RST_SHUTDOWN = 8'h05;
	localparam logic [7:0] RST_SERIAL0  = 8'h30;

	// Writable bit masks; other bits are reserved and read as zero.
	// Sleep register: only bit 1 is read-only; the quick-charge code in bits 4-3 must stick.
	localparam logic [7:0] MASK_SLEEP    = 8'hfd;
	localparam logic [7:0] MASK_SHUTDOWN = 8'h3f;
	localparam logic [7:0] MASK_SERIAL0  = 8'hff;
	localparam int         SOFT_RST_BIT  = 0;

	// Sleep register field positions.
	localparam int SUPPLY_SEL_BIT = 7;
	localparam int REF_QC_LSB     = 3;
	localparam int BCAST_BIT      = 2;
	localparam int WAKE_BIT       = 0;
	// Shutdown register field positions.
	localparam int INCAP_QC_LSB   = 4;
	localparam int SHDN_CODE_LSB  = 2;
	localparam int KEEPALIVE_LSB  = 0;

	// Broadcast slave address, 1001 followed by 100.
	localparam logic [6:0] BCAST_ADDR  = 7'h4c;
	localparam logic [4:0] ADDR_PREFIX = 5'h10;

	// Clock and timing.
	localparam int CLK_HZ = 40_000_000;
	localparam int KA_MS_0 = 30;
	localparam int KA_MS_1 = 25;
	localparam int KA_MS_2 = 10;
	localparam int KA_MS_3 = 5;
	localparam int CYC_PER_MS = CLK_HZ / 1000;

	// Regulator shutdown behaviour codes.
	typedef enum logic [1:0] {
		SHDN_IMMEDIATE = 2'b00,
		SHDN_TIMEOUT   = 2'b01,
		SHDN_CLEAN     = 2'b10,
		SHDN_RESERVED  = 2'b11
	} shdn_code_t;

	// Regulator controller states.
	typedef enum logic [1:0] {
		REG_ON      = 2'b00,
		REG_HOLD    = 2'b01,
		REG_OFF     = 2'b10
	} reg_state_t;

	// Decoded serial audio configuration.
	typedef struct packed {
		logic [1:0] protocol_format;
		logic [1:0] word_length;
		logic       frame_sync_polarity;
		logic       bit_clock_polarity;
		logic       tx_edge;
		logic       tx_fill;
	} serial_cfg_t;

	// Register access request.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] offset;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

// >>> verilog/ctrl_reg_store.sv
// Small register store holding the byte registers of the bank.
// Assumes the parent gives masks and reset values; read data is registered.
`timescale 1ns/1ps
module ctrl_reg_store
	import adc_ctrl_pkg::*;
#(
	parameter int         N = 4
)(
	input  wire logic              clk_in,
	input  wire logic              clear_in,
	input  wire logic [N-1:0]      wr_in,
	input  wire logic [7:0]        wdata_in,
	input  wire logic [N*8-1:0]    init_in,
	input  wire logic [N*8-1:0]    mask_in,
	input  wire logic              rd_in,
	input  wire logic [1:0]        rd_sel_in,
	output logic      [N*8-1:0]    value_out,
	output logic      [7:0]        rdata_out
);
	genvar g;
	// Each byte reloads its power-on value on clear, else takes masked writes.
	generate
		for (g = 0; g < N; g++) begin : g_byte
			always_ff @(posedge clk_in) begin
				if (clear_in) begin
					value_out[g*8 +: 8] <= init_in[g*8 +: 8];
				end else if (wr_in[g]) begin
					value_out[g*8 +: 8] <= wdata_in & mask_in[g*8 +: 8];
				end
			end
		end
	endgenerate

	// Read data is held until the next read so the port sees a stable byte.
	always_ff @(posedge clk_in) begin
		if (clear_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			rdata_out <= value_out[rd_sel_in*8 +: 8];
		end
	end
endmodule

// >>> verilog/audio_adc_ctrl_regs.sv
// Control register bank of a multichannel audio converter.
// Assumes the serial control port has been decoded into byte read and write
// strobes with an offset, all synchronous to clk_in.
// Operation
// - Page register selects active register page.
// - Soft reset returns all registers to defaults.
// - Soft reset bit self clears, reads zero.
// - Bit seven picks external or internal analog rail.
// - Reference fast charge time coded in bits 4-3.
// - Broadcast enable forces fixed 1001100 slave address.
// - Sleep bit zero keeps device asleep.
// - Input capacitor fast charge time in bits 5-4.
// - Shutdown code sets regulator behaviour on shutdown.
// - Keep-alive time code sets regulator hold time.
// - Shutdown register resets to five.
// - Serial config register resets to 30h, fields.
// - Protocol format: TDM, I2S, left-justified.
// - Word length codes 16 to 32 bits.
`timescale 1ns/1ps
module audio_adc_ctrl_regs
	import adc_ctrl_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              nrst_in,
	input  wire reg_req_t          req_in,
	input  wire logic [1:0]        addr_strap_in,
	input  wire logic              shutdown_pin_n_in,
	input  wire logic              clean_shutdown_done_in,
	output logic      [7:0]        rdata_out,
	output logic                   rvalid_out,
	output logic      [7:0]        page_out,
	output logic                   analog_supply_source_sel_out,
	output logic      [1:0]        reference_fastcharge_time_out,
	output logic      [6:0]        slave_addr_out,
	output logic                   awake_out,
	output logic      [1:0]        input_cap_fastcharge_time_out,
	output logic                   digital_regulator_on_out,
	output serial_cfg_t            serial_cfg_out
);
	// Register indices inside the store.
	localparam int IDX_SLEEP = 0;
	localparam int IDX_SHDN  = 1;
	localparam int IDX_SER0  = 2;
	localparam int IDX_PAGE  = 3;
	localparam int NREG      = 4;

	logic [NREG*8-1:0] regs;
	logic [NREG-1:0]   wr_sel;
	logic [7:0]        store_rdata;
	logic              soft_reset_pulse;
	logic              clear;
	logic              rd_d;
	logic              rd_other;
	logic [1:0]        rd_sel;
	logic [7:0]        sleep_reg;
	logic [7:0]        shdn_reg;
	logic [7:0]        page_reg;
	reg_state_t        reg_state;
	logic [20:0]       hold_cnt;
	logic [20:0]       next_hold;

	// Maps a page-zero offset onto a store index; returns NREG when unmapped.
	function automatic int reg_index(input logic [7:0] page, input logic [7:0] ofs);
		if (ofs == OFS_PAGE) begin
			return IDX_PAGE;
		end
		if (page != PAGE_ZERO) begin
			return NREG;
		end
		case (ofs)
			OFS_SLEEP:    return IDX_SLEEP;
			OFS_SHUTDOWN: return IDX_SHDN;
			OFS_SERIAL0:  return IDX_SER0;
			default:      return NREG;
		endcase
	endfunction

	// Keep-alive time in cycles for each code.
	function automatic logic [20:0] keepalive_cycles(input logic [1:0] code);
		case (code)
			2'h0:    return 21'(KA_MS_0 * CYC_PER_MS);
			2'h1:    return 21'(KA_MS_1 * CYC_PER_MS);
			2'h2:    return 21'(KA_MS_2 * CYC_PER_MS);
			default: return 21'(KA_MS_3 * CYC_PER_MS);
		endcase
	endfunction

	assign sleep_reg = regs[IDX_SLEEP*8 +: 8];
	assign shdn_reg  = regs[IDX_SHDN*8 +: 8];
	assign page_reg  = regs[IDX_PAGE*8 +: 8];

	// Soft reset acts as a one-cycle pulse, so the bit never holds a one.
	assign soft_reset_pulse = req_in.wr && (reg_index(page_reg, OFS_PAGE) == IDX_PAGE)
		&& (page_reg == PAGE_ZERO) && (req_in.offset == OFS_SOFT_RST)
		&& req_in.wdata[SOFT_RST_BIT];
	assign clear = !nrst_in || soft_reset_pulse;

	// Write strobes come from page and offset together.
	always_comb begin
		wr_sel = '0;
		if (req_in.wr && reg_index(page_reg, req_in.offset) < NREG) begin
			wr_sel[reg_index(page_reg, req_in.offset)] = 1'b1;
		end
	end
	assign rd_sel   = 2'(reg_index(page_reg, req_in.offset));
	assign rd_other = reg_index(page_reg, req_in.offset) >= NREG;

	ctrl_reg_store #(
		.N(NREG)
	) u_store (
		.clk_in    (clk_in),
		.clear_in  (clear),
		.wr_in     (wr_sel),
		.wdata_in  (req_in.wdata),
		.init_in   ({RST_PAGE, RST_SERIAL0, RST_SHUTDOWN, RST_SLEEP}),
		.mask_in   ({8'hff, MASK_SERIAL0, MASK_SHUTDOWN, MASK_SLEEP}),
		.rd_in     (req_in.rd),
		.rd_sel_in (rd_sel),
		.value_out (regs),
		.rdata_out (store_rdata)
	);

	// Read strobe delay; unmapped offsets and the soft reset register read zero.
	logic rd_zero;
	always_ff @(posedge clk_in) begin
		if (clear) begin
			rd_d    <= 1'b0;
			rd_zero <= 1'b0;
		end else begin
			rd_d    <= req_in.rd;
			rd_zero <= rd_other;
		end
	end

	// Read answer is registered one cycle after the store output.
	always_ff @(posedge clk_in) begin
		if (clear) begin
			rdata_out  <= 8'h00;
			rvalid_out <= 1'b0;
		end else begin
			rvalid_out <= rd_d;
			rdata_out  <= rd_zero ? 8'h00 : store_rdata;
		end
	end

	// Configuration outputs are copied into flops so every output is registered.
	always_ff @(posedge clk_in) begin
		if (clear) begin
			page_out                      <= RST_PAGE;
			analog_supply_source_sel_out  <= 1'b0;
			reference_fastcharge_time_out <= 2'h0;
			awake_out                     <= 1'b0;
			input_cap_fastcharge_time_out <= 2'h0;
			serial_cfg_out                <= RST_SERIAL0;
		end else begin
			page_out                      <= page_reg;
			analog_supply_source_sel_out  <= sleep_reg[SUPPLY_SEL_BIT];
			reference_fastcharge_time_out <= sleep_reg[REF_QC_LSB +: 2];
			awake_out                     <= sleep_reg[WAKE_BIT];
			input_cap_fastcharge_time_out <= shdn_reg[INCAP_QC_LSB +: 2];
			serial_cfg_out                <= regs[IDX_SER0*8 +: 8];
		end
	end

	// Slave address follows the broadcast bit or the strap pins.
	always_ff @(posedge clk_in) begin
		if (clear) begin
			slave_addr_out <= {ADDR_PREFIX, 2'h0};
		end else if (sleep_reg[BCAST_BIT]) begin
			slave_addr_out <= BCAST_ADDR;
		end else begin
			slave_addr_out <= {ADDR_PREFIX, addr_strap_in};
		end
	end

	// Regulator hold timer; the count is reloaded every cycle in REG_ON and counts down to zero in the other states.
	always_comb begin
		next_hold = hold_cnt;
		if (reg_state == REG_ON) begin
			next_hold = keepalive_cycles(shdn_reg[KEEPALIVE_LSB +: 2]);
		end else if (hold_cnt != 21'h0) begin
			next_hold = hold_cnt - 21'h1;
		end
	end

	// Regulator state follows the shutdown code once the pin asserts.
	// The reserved code is treated as immediate power-off, the safe choice.
	always_ff @(posedge clk_in) begin
		if (clear) begin
			reg_state <= REG_ON;
			hold_cnt  <= 21'h0;
			digital_regulator_on_out <= 1'b1;
		end else begin
			hold_cnt <= next_hold;
			case (reg_state)
				REG_ON: begin
					digital_regulator_on_out <= 1'b1;
					if (!shutdown_pin_n_in) begin
						case (shdn_code_t'(shdn_reg[SHDN_CODE_LSB +: 2]))
							SHDN_TIMEOUT, SHDN_CLEAN: reg_state <= REG_HOLD;
							default: begin
								reg_state <= REG_OFF;
								digital_regulator_on_out <= 1'b0;
							end
						endcase
					end
				end
				REG_HOLD: begin
					if (shutdown_pin_n_in) begin
						reg_state <= REG_ON;
					end else if ((shdn_code_t'(shdn_reg[SHDN_CODE_LSB +: 2]) == SHDN_CLEAN
						&& clean_shutdown_done_in) || (shdn_code_t'(shdn_reg[SHDN_CODE_LSB +: 2])
						== SHDN_TIMEOUT && hold_cnt == 21'h0)) begin
						reg_state <= REG_OFF;
						digital_regulator_on_out <= 1'b0;
					end
				end
				REG_OFF: begin
					if (shutdown_pin_n_in) begin
						reg_state <= REG_ON;
						digital_regulator_on_out <= 1'b1;
					end
				end
				default: begin
					reg_state <= REG_ON;
				end
			endcase
		end
	end
endmodule

// >>> verif/audio_adc_ctrl_regs_chk.sv
// Checker for the control register bank, bound to its top ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module audio_adc_ctrl_regs_chk
	import adc_ctrl_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire reg_req_t    req_in,
	input  wire logic        rvalid_out,
	input  wire logic [7:0]  page_out,
	input  wire logic        analog_supply_source_sel_out,
	input  wire logic [6:0]  slave_addr_out,
	input  wire logic        awake_out,
	input  wire logic [1:0]  input_cap_fastcharge_time_out,
	input  wire serial_cfg_t serial_cfg_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// The page copy trails the page register by one edge, so a write that directly
	// follows a page write is left out of the page-zero checks instead of misjudged.
	logic pg_wr_d;
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			pg_wr_d <= 1'b0;
		end else begin
			pg_wr_d <= req_in.wr && (req_in.offset == OFS_PAGE);
		end
	end
	wire pz = req_in.wr && (page_out == PAGE_ZERO) && !pg_wr_d;
	a_read_latency: assert property (req_in.rd |-> ##2 rvalid_out)
		else $error("read not answered");
	a_rvalid_cause: assert property (rvalid_out |-> $past(req_in.rd, 2))
		else $error("answer without read");
	a_page_copy: assert property (req_in.wr && req_in.offset == OFS_PAGE
		|-> ##2 page_out == $past(req_in.wdata, 2)) else $error("page copy wrong");
	a_supply_wake: assert property (pz && req_in.offset == OFS_SLEEP |-> ##2
		{analog_supply_source_sel_out, awake_out} == {$past(req_in.wdata[7], 2),
		$past(req_in.wdata[0], 2)}) else $error("supply or wake copy wrong");
	a_bcast_addr: assert property (pz && req_in.offset == OFS_SLEEP && req_in.wdata[2]
		|-> ##2 slave_addr_out == BCAST_ADDR) else $error("broadcast address wrong");
	a_incap_copy: assert property (pz && req_in.offset == OFS_SHUTDOWN
		|-> ##2 input_cap_fastcharge_time_out == $past(req_in.wdata[5:4], 2))
		else $error("input charge code wrong");
	a_serial_copy: assert property (pz && req_in.offset == OFS_SERIAL0
		|-> ##2 serial_cfg_out == $past(req_in.wdata, 2)) else $error("serial copy wrong");
	a_soft_reset: assert property (pz && req_in.offset == OFS_SOFT_RST && req_in.wdata[0]
		|-> ##2 serial_cfg_out == RST_SERIAL0 && !awake_out) else $error("soft reset missed");
	a_reset_value: assert property ($rose(nrst_in)
		|-> page_out == RST_PAGE && serial_cfg_out == RST_SERIAL0) else $error("bad reset value");
	// Main scenarios seen at least once.
	c_read: cover property (rvalid_out);
	c_bcast: cover property (slave_addr_out == BCAST_ADDR);
	c_page: cover property (page_out != PAGE_ZERO);
endmodule

bind audio_adc_ctrl_regs audio_adc_ctrl_regs_chk u_chk (.clk_in, .nrst_in, .req_in, .rvalid_out,
	.page_out, .analog_supply_source_sel_out, .slave_addr_out, .awake_out,
	.input_cap_fastcharge_time_out, .serial_cfg_out);

// >>> verif/host_model.sv
// Host controller model issuing byte accesses to the register bank.
// Assumes answers to reads come as a registered one-cycle valid pulse.
`timescale 1ns/1ps
module host_model
	import adc_ctrl_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	output reg_req_t        req_out
);
	initial req_out = '0;
	// Offsets are page-relative; the caller sets the page first.
	task automatic write(input logic [7:0] ofs, input logic [7:0] d);
		@(posedge clk_in) #2;
		req_out = '{wr: 1'b1, rd: 1'b0, offset: ofs, wdata: d};
		@(posedge clk_in) #2;
		req_out = '0;
	endtask
	// The answer is awaited for a bounded number of edges so a hang is seen.
	task automatic read(input logic [7:0] ofs, output logic [7:0] d, output bit ok);
		ok = 0;
		d = '0;
		@(posedge clk_in) #2;
		req_out = '{wr: 1'b0, rd: 1'b1, offset: ofs, wdata: 8'h00};
		@(posedge clk_in) #2;
		req_out = '0;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge clk_in) #1;
			if (rvalid_in === 1'b1) begin
				ok = 1;
				d = rdata_in;
			end
		end
	endtask
endmodule

// >>> verif/tb_audio_adc_ctrl_regs.sv
// Self-checking bench for the control register bank.
// Assumes the host model drives requests; pins are driven here.
`timescale 1ns/1ps
module tb_audio_adc_ctrl_regs;
	import adc_ctrl_pkg::*;
	logic        clk_in = 0;
	logic        nrst_in = 0;
	logic [1:0]  strap = 2'b10;
	logic        sd_n = 1;
	logic        done = 0;
	reg_req_t    req;
	logic [7:0]  rdata;
	logic        rvalid;
	logic [7:0]  page;
	logic        sup, awake, reg_on;
	logic [1:0]  refc, incap;
	logic [6:0]  saddr;
	serial_cfg_t scfg;
	int          fail_count = 0;
	int          n_compared = 0;
	logic [7:0]  ofs [5] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h07};
	logic [7:0]  dflt [5] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h30};
	logic [7:0]  msk [5] = '{8'h00, 8'h00, 8'hfd, 8'h3f, 8'hff};
	always #12.5 clk_in = ~clk_in;
	host_model u_host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
	audio_adc_ctrl_regs u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req),
		.addr_strap_in(strap), .shutdown_pin_n_in(sd_n), .clean_shutdown_done_in(done),
		.rdata_out(rdata), .rvalid_out(rvalid), .page_out(page),
		.analog_supply_source_sel_out(sup), .reference_fastcharge_time_out(refc),
		.slave_addr_out(saddr), .awake_out(awake), .input_cap_fastcharge_time_out(incap),
		.digital_regulator_on_out(reg_on), .serial_cfg_out(scfg));
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Byte compare with case inequality so unknowns never match.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// A read that gets no answer is a mismatch and ends the run.
	task automatic rd_chk(input logic [7:0] o, input logic [7:0] exp);
		logic [7:0] d;
		bit         ok;
		u_host.read(o, d, ok);
		if (!ok) begin
			fail_count++;
			$display("[FAIL] %0t no read answer", $time);
			print_verdict();
		end else begin
			check(d, exp);
		end
	endtask
	// Copies lag a write by two edges, so three edges are allowed.
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask
	// Main sequence.
	initial begin
		settle(20);
		nrst_in = 1;
		foreach (ofs[i]) rd_chk(ofs[i], dflt[i]);
		for (int i = 2; i < 5; i++) begin
			u_host.write(ofs[i], 8'hff);
			rd_chk(ofs[i], msk[i]);
		end
		settle(3);
		check({sup, awake, refc, incap, 2'b00}, 8'hfc);
		check({1'b0, saddr}, {1'b0, BCAST_ADDR});
		u_host.write(8'h02, 8'h00);
		settle(3);
		check({1'b0, saddr}, {1'b0, 5'h10, 2'b10});
		check({6'h00, sup, awake}, 8'h00);
		// The strap pins must be followed live while broadcast is off.
		strap = 2'b01;
		settle(3);
		check({1'b0, saddr}, {1'b0, 5'h10, 2'b01});
		for (int f = 0; f < 4; f++) begin
			u_host.write(8'h07, {f[1:0], f[1:0], 4'h5});
			settle(3);
			check(scfg, {f[1:0], f[1:0], 4'h5});
		end
		u_host.write(8'h00, 8'h01);
		rd_chk(8'h00, 8'h01);
		u_host.write(8'h07, 8'h00);
		rd_chk(8'h07, 8'h00);
		u_host.write(8'h00, 8'h00);
		rd_chk(8'h07, 8'hf5);
		u_host.write(8'h01, 8'hfe);
		rd_chk(8'h07, 8'hf5);
		u_host.write(8'h01, 8'h01);
		rd_chk(8'h01, 8'h00);
		rd_chk(8'h07, 8'h30);
		rd_chk(8'h05, 8'h05);
		sd_n = 0;
		settle(100);
		check({7'h0, reg_on}, 8'h01);
		sd_n = 1;
		u_host.write(8'h05, 8'h03);
		sd_n = 0;
		settle(8);
		check({7'h0, reg_on}, 8'h00);
		sd_n = 1;
		u_host.write(8'h05, 8'h08);
		sd_n = 0;
		settle(40);
		check({7'h0, reg_on}, 8'h01);
		done = 1;
		settle(8);
		check({7'h0, reg_on}, 8'h00);
		sd_n = 1;
		settle(8);
		check({7'h0, reg_on}, 8'h01);
		print_verdict();
	end
endmodule
